// ---- include/dmcp_pkg.sv ----
package dmcp_pkg;
    // register map geometry
    localparam int REG_AW = 7;
    localparam int NUM_REGS = 1 << REG_AW;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [REG_AW-1:0] PTR_RESET = 7'h00;
    localparam logic [REG_AW-1:0] PTR_STEP = 7'h01;
    // pointer byte: low bits select, top bit enables auto step
    localparam int PTR_STEP_BIT = 7;
    // chip addresses
    localparam logic [6:0] SPI_CHIP_ADDR = 7'h4f;
    localparam logic [4:0] I2C_ADDR_HI = 5'h13;
    // bit counter values
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // write count crossing
    localparam logic [3:0] WR_CNT_RESET = 4'h0;
    localparam logic [3:0] WR_CNT_STEP = 4'h1;
    localparam logic [1:0] SETTLE_RESET = 2'h0;
    localparam logic [1:0] SETTLE_STEP = 2'h1;
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    localparam logic [1:0] EVENT_RESET = 2'h0;

    typedef enum logic [4:0] {
        ST_ADDR = 5'h01,
        ST_PTR = 5'h02,
        ST_DATA = 5'h04,
        ST_READ = 5'h08,
        ST_IGNORE = 5'h10
    } dmcp_state_t;

    function automatic logic [3:0] dmcp_bin2gray(input logic [3:0] b);
        return b ^ (b >> 1);
    endfunction : dmcp_bin2gray
endpackage : dmcp_pkg

// ---- include/dmcp_xfer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dmcp_xfer_if;
    import dmcp_pkg::*;
    logic port_rst_b;
    logic [1:0] strap;
    logic [3:0] wr_gray;
    logic [7:0] link_regs [NUM_REGS];
    modport core (
        output port_rst_b,
        output strap,
        input wr_gray,
        input link_regs
    );
    modport link (
        input port_rst_b,
        input strap,
        output wr_gray,
        output link_regs
    );
endinterface : dmcp_xfer_if
`default_nettype wire

// ---- rtl/dmcp_core_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmcp_core_side
    import dmcp_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // address straps, raw pins
    input wire logic strap_bit0_pin,
    input wire logic strap_bit1_pin,
    // core read port
    input wire logic [REG_AW-1:0] core_rd_addr,
    output logic [7:0] core_rd_data,
    output logic regs_updated,
    // link side
    dmcp_xfer_if.core xf
);
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic [3:0] gray_meta;
    logic [3:0] gray_sync;
    logic [3:0] gray_prev;
    logic [3:0] gray_done;
    logic [1:0] settle;
    logic [7:0] mirror [NUM_REGS];

    // link side leaves reset one clock after rst_b, while its clock is idle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xf.port_rst_b <= 1'b0;
        end else begin
            xf.port_rst_b <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        strap_meta <= {strap_bit1_pin, strap_bit0_pin};
        strap_sync <= strap_meta;
    end

    // straps are caught only while reset is held
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xf.strap <= strap_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gray_meta <= WR_CNT_RESET;
            gray_sync <= WR_CNT_RESET;
            gray_prev <= WR_CNT_RESET;
        end else begin
            gray_meta <= xf.wr_gray;
            gray_sync <= gray_meta;
            gray_prev <= gray_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle <= SETTLE_RESET;
        end else if (gray_sync != gray_prev) begin
            settle <= SETTLE_RESET;
        end else if (settle != SETTLE_CYCLES) begin
            settle <= settle + SETTLE_STEP;
        end
    end

    // copy only once the write count has stood still: a long burst of
    // writes defers the copy, but never tears a register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mirror[i] <= REG_RESET;
            end
            gray_done <= WR_CNT_RESET;
            regs_updated <= 1'b0;
        end else begin
            regs_updated <= 1'b0;
            if (settle == SETTLE_CYCLES && gray_sync != gray_done) begin
                for (int i = 0; i < NUM_REGS; i++) begin
                    mirror[i] <= xf.link_regs[i];
                end
                gray_done <= gray_sync;
                regs_updated <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_rd_data <= REG_RESET;
        end else begin
            core_rd_data <= mirror[core_rd_addr];
        end
    end
endmodule : dmcp_core_side
`default_nettype wire

// ---- rtl/dmcp_control_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmcp_control_port
    import dmcp_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control link pins
    input wire logic control_bit_clock,
    input wire logic control_serial_in,
    input wire logic strap_or_select_pin,
    input wire logic addr_strap_bit1,
    // four-wire serial output, three-state
    output logic control_serial_out,
    output logic control_serial_out_oe,
    // two-wire data pin, pulled low when enabled
    output logic bus_data_out,
    output logic bus_data_oe,
    // core read port
    input wire logic [REG_AW-1:0] core_rd_addr,
    output logic [7:0] core_rd_data,
    output logic regs_updated,
    // status towards the core
    output logic spi_mode_active,
    output logic link_start_pulse,
    output logic link_stop_pulse
);
    dmcp_xfer_if xf ();

    // link clock domain
    logic spi_mode;
    logic frame_clr_b;
    logic start_tog;
    logic stop_tog;
    logic start_seen;
    logic start_pend;
    dmcp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] byte_in;
    logic byte_done;
    logic take_byte;
    logic addr_hit;
    logic [6:0] my_addr;
    logic [REG_AW-1:0] ptr;
    logic ptr_step;
    logic ack_due;
    logic [3:0] wr_bin;
    logic [7:0] rd_byte;
    logic rd_bit;
    logic read_over;
    logic ptr_take;
    logic wr_take;

    // system clock domain
    logic mode_meta;
    logic [1:0] ev_meta;
    logic [1:0] ev_sync;
    logic [1:0] ev_prev;

    dmcp_core_side u_core (
        .clk(clk),
        .rst_b(rst_b),
        .strap_bit0_pin(strap_or_select_pin),
        .strap_bit1_pin(addr_strap_bit1),
        .core_rd_addr(core_rd_addr),
        .core_rd_data(core_rd_data),
        .regs_updated(regs_updated),
        .xf(xf)
    );

    // combinational view of the incoming byte, newest bit last
    assign byte_in = {shreg[6:0], control_serial_in};
    assign byte_done = (bit_cnt == LAST_DATA_BIT);
    assign start_pend = !spi_mode && (start_tog != start_seen);
    assign take_byte = byte_done && !start_pend;
    assign my_addr = spi_mode ? SPI_CHIP_ADDR
                              : {I2C_ADDR_HI, xf.strap};
    assign addr_hit = (byte_in[7:1] == my_addr);
    assign rd_byte = xf.link_regs[ptr];
    assign rd_bit = rd_byte[3'(LAST_DATA_BIT - bit_cnt)];
    // the address acknowledge leaves ack_due high, so it never ends a read
    assign read_over = (state == ST_READ) && !ack_due;
    assign ptr_take = take_byte && (state == ST_PTR);
    assign wr_take = take_byte && (state == ST_DATA);

    // chip select high ends a four-wire frame at once, with no clock edge
    assign frame_clr_b = xf.port_rst_b & ~(spi_mode & strap_or_select_pin);

    // the select pin only ever falls in four-wire use; a strap never moves
    always_ff @(negedge strap_or_select_pin or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            spi_mode <= 1'b0;
        end else begin
            spi_mode <= 1'b1;
        end
    end

    // start: data falls while the clock is high
    always_ff @(negedge control_serial_in or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            start_tog <= 1'b0;
        end else if (control_bit_clock && !spi_mode) begin
            start_tog <= ~start_tog;
        end
    end

    // stop: data rises while the clock is high
    always_ff @(posedge control_serial_in or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            stop_tog <= 1'b0;
        end else if (control_bit_clock && !spi_mode) begin
            stop_tog <= ~stop_tog;
        end
    end

    always_ff @(posedge control_bit_clock or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            start_seen <= 1'b0;
        end else begin
            start_seen <= start_tog;
        end
    end

    // framing: bits are taken on the rising edge
    always_ff @(posedge control_bit_clock or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            state <= ST_ADDR;
            bit_cnt <= CNT_RESET;
            shreg <= REG_RESET;
            ack_due <= 1'b0;
        end else if (start_pend) begin
            // first address bit arrives on the edge that sees the start
            state <= ST_ADDR;
            bit_cnt <= CNT_STEP;
            shreg <= byte_in;
            ack_due <= 1'b0;
        end else if (!spi_mode && bit_cnt == ACK_SLOT) begin
            bit_cnt <= CNT_RESET;
            ack_due <= 1'b0;
            // one register per read; the host's answer only ends it
            if (read_over) begin
                state <= ST_IGNORE;
            end
        end else begin
            shreg <= byte_in;
            if (!byte_done) begin
                bit_cnt <= bit_cnt + CNT_STEP;
            end else if (spi_mode) begin
                bit_cnt <= CNT_RESET;
            end else begin
                bit_cnt <= ACK_SLOT;
            end
            if (byte_done) begin
                case (state)
                    ST_ADDR: begin
                        ack_due <= addr_hit;
                        if (!addr_hit) begin
                            state <= ST_IGNORE;
                        end else if (byte_in[0]) begin
                            state <= ST_READ;
                        end else begin
                            state <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        state <= ST_DATA;
                        ack_due <= 1'b1;
                    end
                    ST_DATA: begin
                        ack_due <= 1'b1;
                    end
                    default: begin
                        ack_due <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pointer outlives a frame; only the port reset clears it
    always_ff @(posedge control_bit_clock or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            ptr <= PTR_RESET;
            ptr_step <= 1'b0;
        end else if (ptr_take) begin
            ptr <= byte_in[REG_AW-1:0];
            ptr_step <= byte_in[PTR_STEP_BIT];
        end else if (wr_take && ptr_step) begin
            ptr <= ptr + PTR_STEP;
        end
    end

    // registers and the write count outlive a frame as well
    always_ff @(posedge control_bit_clock or negedge xf.port_rst_b) begin
        if (!xf.port_rst_b) begin
            wr_bin <= WR_CNT_RESET;
            xf.wr_gray <= WR_CNT_RESET;
            for (int i = 0; i < NUM_REGS; i++) begin
                xf.link_regs[i] <= REG_RESET;
            end
        end else if (wr_take) begin
            xf.link_regs[ptr] <= byte_in;
            wr_bin <= wr_bin + WR_CNT_STEP;
            // gray count: the core never sees two bits move at once
            xf.wr_gray <= dmcp_bin2gray(wr_bin + WR_CNT_STEP);
        end
    end

    // drivers change on the falling edge, never while the clock is high
    always_ff @(negedge control_bit_clock or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            control_serial_out <= 1'b0;
            control_serial_out_oe <= 1'b0;
        end else if (spi_mode) begin
            // only an addressed read leaves high impedance
            control_serial_out_oe <= (state == ST_READ);
            control_serial_out <= rd_bit;
        end else begin
            control_serial_out <= 1'b0;
            control_serial_out_oe <= 1'b0;
        end
    end

    // the two-wire pull moves on the falling edge too
    always_ff @(negedge control_bit_clock or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            bus_data_oe <= 1'b0;
        end else if (spi_mode || start_pend) begin
            bus_data_oe <= 1'b0;
        end else if (bit_cnt == ACK_SLOT) begin
            bus_data_oe <= ack_due;
        end else if (state == ST_READ) begin
            bus_data_oe <= !rd_bit;
        end else begin
            bus_data_oe <= 1'b0;
        end
    end

    // open drain: the data pin is only ever pulled low
    always_ff @(posedge clk) begin
        bus_data_out <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_meta <= 1'b0;
            spi_mode_active <= 1'b0;
        end else begin
            mode_meta <= spi_mode;
            spi_mode_active <= mode_meta;
        end
    end

    // frame edges reach the core as toggles, then one-cycle pulses
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ev_meta <= EVENT_RESET;
            ev_sync <= EVENT_RESET;
            ev_prev <= EVENT_RESET;
        end else begin
            ev_meta <= {stop_tog, start_tog};
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link_start_pulse <= 1'b0;
            link_stop_pulse <= 1'b0;
        end else begin
            link_start_pulse <= ev_sync[0] ^ ev_prev[0];
            link_stop_pulse <= ev_sync[1] ^ ev_prev[1];
        end
    end
endmodule : dmcp_control_port
`default_nettype wire

// ---- verification/dmcp_control_port_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmcp_control_port_monitor (
    // clocks and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic control_bit_clock,
    // watched pins
    input wire logic strap_or_select_pin,
    input wire logic control_serial_out_oe,
    input wire logic bus_data_oe,
    input wire logic spi_mode_active,
    input wire logic link_start_pulse
);
    logic sel_fell;
    // a select fall is the only thing allowed to enter four-wire mode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_fell <= 1'b0;
        end else if ($fell(strap_or_select_pin)) begin
            sel_fell <= 1'b1;
        end
    end
    sequence sel_drop;
        $fell(strap_or_select_pin);
    endsequence
    sequence mode_on;
        ##[1:4] spi_mode_active;
    endsequence
    chk_quiet_reset: assert property (
        @(posedge clk) disable iff (!rst_b) $rose(rst_b) |->
        !control_serial_out_oe && !bus_data_oe && !spi_mode_active)
        else $error("outputs active out of reset");
    chk_mode_select: assert property (
        @(posedge clk) disable iff (!rst_b) sel_drop |-> mode_on)
        else $error("select fall did not enter four-wire mode");
    chk_mode_sticky: assert property (
        @(posedge clk) disable iff (!rst_b)
        spi_mode_active |=> spi_mode_active)
        else $error("four-wire mode dropped");
    chk_mode_cause: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(spi_mode_active) |-> sel_fell)
        else $error("four-wire mode without select fall");
    chk_spi_no_sda: assert property (
        @(posedge clk) disable iff (!rst_b)
        spi_mode_active |-> !bus_data_oe)
        else $error("two-wire pull in four-wire mode");
    chk_oe_release: assert property (
        @(posedge clk) disable iff (!rst_b)
        $fell(control_serial_out_oe) |-> strap_or_select_pin)
        else $error("serial out released while selected");
    chk_oe_selected: assert property (
        @(posedge control_bit_clock) disable iff (!rst_b)
        control_serial_out_oe |-> !strap_or_select_pin)
        else $error("serial out driven while deselected");
    chk_start_single: assert property (
        @(posedge clk) disable iff (!rst_b)
        link_start_pulse |=> !link_start_pulse && !spi_mode_active)
        else $error("start pulse too long or in four-wire mode");
endmodule : dmcp_control_port_monitor
bind dmcp_control_port dmcp_control_port_monitor i_dmcp_control_port_monitor (
    .clk(clk),
    .rst_b(rst_b),
    .control_bit_clock(control_bit_clock),
    .strap_or_select_pin(strap_or_select_pin),
    .control_serial_out_oe(control_serial_out_oe),
    .bus_data_oe(bus_data_oe),
    .spi_mode_active(spi_mode_active),
    .link_start_pulse(link_start_pulse)
);
`default_nettype wire

// ---- verification/dmcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmcp_host_model (
    // link pins towards the device
    output logic link_clk,
    output logic din,
    output logic sel,
    // device answers
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic sda_pull_oe
);
    logic d;
    logic oe_seen;
    // pulled-up data wire: low if either side pulls
    assign din = d & ~sda_pull_oe;
    initial begin
        link_clk = 1'b1;
        d = 1'b1;
        sel = 1'b1;
        oe_seen = 1'b0;
    end
    always @(posedge dout_oe) oe_seen = 1'b1;
    task automatic spi_idle();
        link_clk = 1'b0;
    endtask : spi_idle
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            d = tx[i];
            #7.5 link_clk = 1'b1;
            rx[i] = dout_oe ? dout : ~dout;
            #7.5 link_clk = 1'b0;
        end
    endtask : spi_byte
    // long gap keeps pins static between frames
    task automatic spi_frame(input int n, input logic [31:0] tx,
                             output logic [31:0] rx);
        logic [7:0] b;
        rx = '0;
        sel = 1'b0;
        #7.5;
        for (int k = 0; k < n; k++) begin
            spi_byte(tx[31 - 8 * k -: 8], b);
            rx[31 - 8 * k -: 8] = b;
        end
        #7.5 sel = 1'b1;
        #250;
    endtask : spi_frame
    task automatic i2c_start();
        d = 1'b1;
        #7.5 link_clk = 1'b1;
        #7.5 d = 1'b0;
        #7.5 link_clk = 1'b0;
    endtask : i2c_start
    task automatic i2c_stop();
        d = 1'b0;
        #7.5 link_clk = 1'b1;
        #7.5 d = 1'b1;
        #250;
    endtask : i2c_stop
    task automatic i2c_bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            d = tx[i];
            #7.5 link_clk = 1'b1;
            rx[i] = din;
            #7.5 link_clk = 1'b0;
        end
    endtask : i2c_bits
endmodule : dmcp_host_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dmcp_pkg::*;
    logic clk;
    logic rst_b;
    logic strap1;
    logic [REG_AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic link_clk, din, sel, dout, dout_oe, sda_oe, upd, spi_on;
    logic [8:0] rx9;
    logic [31:0] rx;
    logic sda_out, start_p, stop_p;
    int starts = 0;
    int stops = 0;
    int num_errors = 0;
    int compares = 0;
    dmcp_control_port i_dmcp_control_port (
        .clk(clk), .rst_b(rst_b), .control_bit_clock(link_clk),
        .control_serial_in(din), .strap_or_select_pin(sel),
        .addr_strap_bit1(strap1), .control_serial_out(dout),
        .control_serial_out_oe(dout_oe), .bus_data_out(sda_out),
        .bus_data_oe(sda_oe), .core_rd_addr(rd_addr),
        .core_rd_data(rd_data), .regs_updated(upd),
        .spi_mode_active(spi_on), .link_start_pulse(start_p),
        .link_stop_pulse(stop_p));
    dmcp_host_model i_dmcp_host_model (.link_clk(link_clk), .din(din),
        .sel(sel), .dout(dout), .dout_oe(dout_oe), .sda_pull_oe(sda_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // frame edge pulses counted away from the edge that launches them
    always @(negedge clk) begin
        if (start_p === 1'b1) begin
            starts++;
        end
        if (stop_p === 1'b1) begin
            stops++;
        end
    end
    task automatic report_and_stop();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset();
        @(posedge clk) rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : do_reset
    task automatic core_rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk) rd_addr <= a;
        repeat (2) @(posedge clk);
        #1 check("register", rd_data, exp);
    endtask : core_rd
    task automatic wait_upd();
        repeat (60) begin
            @(posedge clk);
            #1;
            if (upd === 1'b1) return;
        end
        num_errors++;
        $display("[FAIL] mirror update expected 1 seen 0");
        report_and_stop();
    endtask : wait_upd
    task automatic i2c_wr(input logic [7:0] b, input logic ack);
        i_dmcp_host_model.i2c_bits({b, 1'b1}, rx9);
        check("ack", {7'h00, rx9[0]}, {7'h00, !ack});
    endtask : i2c_wr
    task automatic t_reset_state();
        #1 check("outputs", {dout_oe, sda_oe, spi_on}, 8'h00);
        core_rd(7'h05, 8'h00);
        $display("reset state done");
    endtask : t_reset_state
    task automatic t_i2c_write();
        i_dmcp_host_model.i2c_start();
        i2c_wr(8'h9a, 1'b1);
        i2c_wr(8'h85, 1'b1);
        i2c_wr(8'ha1, 1'b1);
        i2c_wr(8'hb2, 1'b1);
        i_dmcp_host_model.i2c_stop();
        wait_upd();
        core_rd(7'h05, 8'ha1);
        core_rd(7'h06, 8'hb2);
        check("start count", 8'(starts), 8'h01);
        check("stop count", 8'(stops), 8'h01);
        check("data value", {7'h00, sda_out}, 8'h00);
        $display("two-wire write done");
    endtask : t_i2c_write
    task automatic t_i2c_read();
        i_dmcp_host_model.i2c_start();
        i2c_wr(8'h9a, 1'b1);
        i2c_wr(8'h86, 1'b1);
        i_dmcp_host_model.i2c_stop();
        repeat (2) begin
            i_dmcp_host_model.i2c_start();
            i2c_wr(8'h9b, 1'b1);
            i_dmcp_host_model.i2c_bits({8'hff, 1'b0}, rx9);
            check("read byte", rx9[8:1], 8'hb2);
            i_dmcp_host_model.i2c_stop();
        end
        $display("two-wire read done");
    endtask : t_i2c_read
    task automatic t_i2c_foreign();
        for (int i = 0; i < 2; i++) begin
            i_dmcp_host_model.i2c_start();
            i2c_wr(i ? 8'hda : 8'h98, 1'b0);
            i2c_wr(8'h05, 1'b0);
            i_dmcp_host_model.i2c_stop();
        end
        $display("foreign address done");
    endtask : t_i2c_foreign
    task automatic t_spi_write();
        i_dmcp_host_model.oe_seen = 1'b0;
        i_dmcp_host_model.spi_frame(4, 32'h9e10_1122, rx);
        check("four-wire mode", spi_on, 8'h01);
        i_dmcp_host_model.spi_frame(4, 32'h9e94_3344, rx);
        wait_upd();
        core_rd(7'h10, 8'h22);
        core_rd(7'h11, 8'h00);
        core_rd(7'h14, 8'h33);
        core_rd(7'h15, 8'h44);
        check("start count", 8'(starts), 8'h06);
        check("stop count", 8'(stops), 8'h06);
        check("write drive", i_dmcp_host_model.oe_seen, 8'h00);
        $display("four-wire write done");
    endtask : t_spi_write
    task automatic t_spi_read();
        i_dmcp_host_model.spi_frame(2, 32'h9e10_0000, rx);
        i_dmcp_host_model.spi_frame(3, 32'h9f00_0000, rx);
        check("read byte", rx[23:16], 8'h22);
        check("repeat byte", rx[15:8], 8'h22);
        check("released", dout_oe, 8'h00);
        i_dmcp_host_model.oe_seen = 1'b0;
        i_dmcp_host_model.spi_frame(3, 32'h9d00_0000, rx);
        check("foreign drive", i_dmcp_host_model.oe_seen, 8'h00);
        $display("four-wire read done");
    endtask : t_spi_read
    initial begin
        #1_000_000;
        num_errors++;
        $display("[FAIL] run time expected end seen timeout");
        report_and_stop();
    end
    initial begin
        rst_b = 1'b0;
        strap1 = 1'b0;
        rd_addr = '0;
        do_reset();
        t_reset_state();
        t_i2c_write();
        t_i2c_read();
        t_i2c_foreign();
        i_dmcp_host_model.spi_idle();
        do_reset();
        t_reset_state();
        t_spi_write();
        t_spi_read();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
